// ===== rtl/buck_seq_map.vh
/*
 Timing counts, field codes and reset values for the step-down converter sequencer.
 Assumes a 10 MHz system clock.
*/
`ifndef BUCK_SEQ_MAP_VH
`define BUCK_SEQ_MAP_VH
`define CLK_PERIOD_NS 100
`define SHORT_COUNT_LIMIT 5'h10
`define FAULT_OFF_TIME_US 2000
`define FAULT_OFF_CYCLES ((`FAULT_OFF_TIME_US * 1000) / `CLK_PERIOD_NS)
`define DELAY_UNIT_TIME_US 2000
`define DELAY_UNIT_CYCLES ((`DELAY_UNIT_TIME_US * 1000) / `CLK_PERIOD_NS)
`define BOOT_DISCHARGE_TIME_US 100
`define BOOT_DISCHARGE_CYCLES ((`BOOT_DISCHARGE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define WAKEUP_TIME_US 50
`define WAKEUP_CYCLES ((`WAKEUP_TIME_US * 1000) / `CLK_PERIOD_NS)
`define INIT_TIME_US 50
`define INIT_CYCLES ((`INIT_TIME_US * 1000) / `CLK_PERIOD_NS)
`define RAMP_RATE_00_CYCLES 16'h000a
`define RAMP_RATE_01_CYCLES 16'h0014
`define RAMP_RATE_10_CYCLES 16'h0028
`define RAMP_RATE_11_CYCLES 16'h0050
`define IPEAK_CODE_5A2 2'h0
`define IPEAK_CODE_5A8 2'h1
`define IPEAK_CODE_6A2 2'h2
`define IPEAK_CODE_6A8 2'h3
`define PREWARN_DEFAULT 2'h0
`endif

// ===== rtl/buck_control_sequencer.v
/*
 Digital sequencer of a step-down regulator: modes, power-up sequences, configuration
 select, peak and short-circuit handling, thermal gating, discharge and voltage ramp.
 Assumes register bits arrive as plain ports from a register block on the same clock,
 and that nrst is the undervoltage reset. Pins and analog comparators are synchronised, except peak_comp on its path to hs_switch_off.
*/
// Contract
// RL1 - Sixteen consecutive peak events power down for 2 ms and flag short circuit.
// RL2 - After short fault: restart after 2 ms if auto restart, else wait enable toggle.
// RL3 - High-side current above peak threshold opens the high-side switch at once.
// RL4 - Two-bit peak select picks 5.2, 5.8, 6.2 or 6.8 A threshold.
// RL5 - Seven-bit code selects target voltage; writing the active code changes output.
// RL6 - Below undervoltage threshold all logic held in reset, converter off.
// RL7 - Thermal shutdown only acts while output on, and turns output off.
// RL8 - After thermal shutdown restart needs enable toggle unless auto restart set.
// RL9 - Thermal warning and pre-warning sources; pre-warning threshold selectable, default 105C.
// RL10 - Discharge on first 100 us after power, and on shutdown when enabled.
// RL11 - Enable low: converter off, sleep if sleep bit or select high, else off.
// RL12 - Enable high: selected enable bit turns converter on, else sleep mode.
// RL13 - Enable pin edges never reset registers or internal state.
// RL14 - During wake-up time every I2C request is not acknowledged.
// RL15 - Three-bit delay adds 2 ms units of power-up delay, default zero.
// RL16 - Enable rise: normal from off, quick from sleep; bit or select: fast.
// RL17 - Power-up voltage target follows configuration chosen by current select state.
// RL18 - Enable grounded keeps core and I2C alive; clearing enable bit shuts down.
// RL19 - Rewriting active code or switching selected code starts a voltage ramp.
// RL20 - Ramp uses fixed step with rate set by two-bit ramp rate field.
// RL21 - Forced ramp mode controls both slopes; auto mode controls only rise.
// RL22 - Select picks enable, code and mode bits; gate low forces high set.
// RL23 - Selected forced mode bit keeps pseudo-PWM and blocks pulse-frequency transition.
// RL24 - Peak counter clears on any cycle without peak and on restart.
`timescale 1ns/1ps
`include "buck_seq_map.vh"
module buck_control_sequencer #(
  parameter FAULT_OFF_CYCLES = `FAULT_OFF_CYCLES,
  parameter DELAY_UNIT_CYCLES = `DELAY_UNIT_CYCLES,
  parameter BOOT_DISCHARGE_CYCLES = `BOOT_DISCHARGE_CYCLES
) (
  input wire clock,
  input wire nrst,
  input wire clk_en,
  input wire enable_pin,
  input wire config_select_pin,
  input wire select_pin_gate,
  input wire sleep_on_disable,
  input wire conv_enable_low,
  input wire conv_enable_high,
  input wire [6:0] vout_code_low,
  input wire [6:0] vout_code_high,
  input wire vout_low_write,
  input wire vout_high_write,
  input wire forced_mode_low,
  input wire forced_mode_high,
  input wire ramp_transition_mode,
  input wire [1:0] voltage_ramp_rate,
  input wire [2:0] powerup_delay,
  input wire [1:0] peak_limit_sel,
  input wire auto_restart_enable,
  input wire discharge_enable,
  input wire [1:0] prewarn_threshold_sel,
  input wire cycle_start,
  input wire peak_comp,
  input wire thermal_shutdown,
  input wire thermal_warn_comp,
  input wire prewarn_comp,
  output reg [1:0] peak_threshold_code,
  output wire hs_switch_off,
  output reg converter_on_q,
  output reg [6:0] vout_target_q,
  output reg pfm_allowed_q,
  output reg ramp_down_active_q,
  output reg discharge_on_q,
  output reg short_circuit_flag,
  output reg thermal_shutdown_flag,
  output reg thermal_warn_flag,
  output reg prewarn_flag,
  output reg [1:0] prewarn_level_q,
  output reg i2c_ready_q,
  output reg sleep_mode_q,
  output reg off_mode_q,
  output reg [2:0] seq_kind_q
);

// ----------------------------------------------------------------
// States and pin synchronisers
// ----------------------------------------------------------------
localparam [5:0] ST_WAKE = 6'h01;
localparam [5:0] ST_IDLE = 6'h02;
localparam [5:0] ST_DELAY = 6'h04;
localparam [5:0] ST_INIT = 6'h08;
localparam [5:0] ST_RUN = 6'h10;
localparam [5:0] ST_FAULT = 6'h20;
localparam [2:0] SEQ_NORMAL = 3'h1;
localparam [2:0] SEQ_QUICK = 3'h2;
localparam [2:0] SEQ_FAST = 3'h4;

reg [5:0] state_q;
reg [31:0] timer_q;
reg [4:0] peak_cnt_q;
reg [31:0] boot_cnt_q;
reg [15:0] ramp_cnt_q;
reg [6:0] ramp_goal_q;
reg latch_off_q;
reg en_prev_q;
reg use_low_q;
reg [2:0] en_sync_q;
reg [2:0] sel_sync_q;
reg [2:0] pk_sync_q;
reg [2:0] tsd_sync_q;
reg [2:0] tw_sync_q;
reg [2:0] pw_sync_q;
reg [2:0] cyc_sync_q;
reg en_s_q;
reg sel_s_q;
reg pk_s_q;
reg tsd_s_q;
reg tw_s_q;
reg pw_s_q;
reg cyc_s_q;
reg cyc_prev_q;

// Three-stage sync; level accepted once stages two and three agree
function filt;
  input [2:0] s;
  input cur;
  begin
    filt = (s[1] == s[2]) ? s[2] : cur;
  end
endfunction

function [15:0] ramp_period;
  input [1:0] rate;
  begin
    case (rate)
      2'h0: ramp_period = `RAMP_RATE_00_CYCLES;
      2'h1: ramp_period = `RAMP_RATE_01_CYCLES;
      2'h2: ramp_period = `RAMP_RATE_10_CYCLES;
      default: ramp_period = `RAMP_RATE_11_CYCLES;
    endcase
  end
endfunction

// RL6 nrst is the undervoltage reset of all state
always @(posedge clock or negedge nrst) begin
  if (!nrst) begin
    en_sync_q <= 3'h0;
    sel_sync_q <= 3'h0;
    pk_sync_q <= 3'h0;
    tsd_sync_q <= 3'h0;
    tw_sync_q <= 3'h0;
    pw_sync_q <= 3'h0;
    cyc_sync_q <= 3'h0;
    en_s_q <= 1'b0;
    sel_s_q <= 1'b0;
    pk_s_q <= 1'b0;
    tsd_s_q <= 1'b0;
    tw_s_q <= 1'b0;
    pw_s_q <= 1'b0;
    cyc_s_q <= 1'b0;
  end else if (clk_en) begin
    en_sync_q <= {en_sync_q[1:0], enable_pin};
    sel_sync_q <= {sel_sync_q[1:0], config_select_pin};
    pk_sync_q <= {pk_sync_q[1:0], peak_comp};
    tsd_sync_q <= {tsd_sync_q[1:0], thermal_shutdown};
    tw_sync_q <= {tw_sync_q[1:0], thermal_warn_comp};
    pw_sync_q <= {pw_sync_q[1:0], prewarn_comp};
    cyc_sync_q <= {cyc_sync_q[1:0], cycle_start};
    en_s_q <= filt(en_sync_q, en_s_q);
    sel_s_q <= filt(sel_sync_q, sel_s_q);
    pk_s_q <= filt(pk_sync_q, pk_s_q);
    tsd_s_q <= filt(tsd_sync_q, tsd_s_q);
    tw_s_q <= filt(tw_sync_q, tw_s_q);
    pw_s_q <= filt(pw_sync_q, pw_s_q);
    cyc_s_q <= filt(cyc_sync_q, cyc_s_q);
  end
end

// ----------------------------------------------------------------
// Configuration selection
// ----------------------------------------------------------------
// RL22 gate low forces the high-side set
wire use_low = select_pin_gate & ~sel_s_q;
wire sel_enable = use_low ? conv_enable_low : conv_enable_high;
// RL17 target follows current select state
wire [6:0] sel_code = use_low ? vout_code_low : vout_code_high;
wire sel_forced = use_low ? forced_mode_low : forced_mode_high;
wire active_write = use_low ? vout_low_write : vout_high_write;
wire en_rise = en_s_q & ~en_prev_q;
wire en_fall = ~en_s_q & en_prev_q;
wire cyc_edge = cyc_s_q & ~cyc_prev_q;
wire tsd_hit = converter_on_q & tsd_s_q;

// RL3 immediate open, no synchroniser in the path
assign hs_switch_off = peak_comp;

// RL4 threshold code passed to the analog comparator
always @* begin
  case (peak_limit_sel)
    2'h0: peak_threshold_code = `IPEAK_CODE_5A2;
    2'h1: peak_threshold_code = `IPEAK_CODE_5A8;
    2'h2: peak_threshold_code = `IPEAK_CODE_6A2;
    default: peak_threshold_code = `IPEAK_CODE_6A8;
  endcase
end

// ----------------------------------------------------------------
// Power-up sequencer and fault handling
// ----------------------------------------------------------------
always @(posedge clock or negedge nrst) begin
  if (!nrst) begin
    state_q <= ST_WAKE;
    timer_q <= 32'h0;
    peak_cnt_q <= 5'h0;
    latch_off_q <= 1'b0;
    en_prev_q <= 1'b0;
    use_low_q <= 1'b0;
    cyc_prev_q <= 1'b0;
    converter_on_q <= 1'b0;
    short_circuit_flag <= 1'b0;
    thermal_shutdown_flag <= 1'b0;
    i2c_ready_q <= 1'b0;
    seq_kind_q <= SEQ_NORMAL;
    sleep_mode_q <= 1'b0;
    off_mode_q <= 1'b1;
  end else if (clk_en) begin
    // RL13 enable edges only steer the sequencer
    en_prev_q <= en_s_q;
    use_low_q <= use_low;
    cyc_prev_q <= cyc_s_q;
    // RL11 mode when enable low; RL12 sleep when enable high and bit clear
    sleep_mode_q <= en_s_q ? ~sel_enable : (sleep_on_disable | sel_s_q);
    off_mode_q <= ~en_s_q & ~sleep_on_disable & ~sel_s_q;
    // RL8 enable toggle releases a latched fault
    if (en_fall) begin
      latch_off_q <= 1'b0;
    end
    case (state_q)
      ST_WAKE: begin
        // RL14 requests refused until wake-up is over
        if (timer_q >= `WAKEUP_CYCLES - 1) begin
          i2c_ready_q <= 1'b1;
          timer_q <= 32'h0;
          state_q <= ST_IDLE;
        end else begin
          timer_q <= timer_q + 32'h1;
        end
      end
      ST_IDLE: begin
        converter_on_q <= 1'b0;
        timer_q <= 32'h0;
        // RL8 restart waits for thermal recovery
        if (en_s_q & sel_enable & ~latch_off_q & ~tsd_s_q) begin
          // RL16 pin rise uses delay, bit or select does not
          if (en_rise) begin
            seq_kind_q <= sleep_mode_q ? SEQ_QUICK : SEQ_NORMAL;
            state_q <= ST_DELAY;
          end else begin
            seq_kind_q <= SEQ_FAST;
            state_q <= ST_INIT;
          end
        end
      end
      ST_DELAY: begin
        // RL15 delay field in 2 ms units
        if (!en_s_q) begin
          state_q <= ST_IDLE;
        end else if (timer_q >= {29'h0, powerup_delay} * DELAY_UNIT_CYCLES) begin
          timer_q <= 32'h0;
          state_q <= ST_INIT;
        end else begin
          timer_q <= timer_q + 32'h1;
        end
      end
      ST_INIT: begin
        if (!(en_s_q & sel_enable)) begin
          state_q <= ST_IDLE;
        end else if (timer_q >= `INIT_CYCLES - 1) begin
          timer_q <= 32'h0;
          // RL24 counter cleared on restart
          peak_cnt_q <= 5'h0;
          converter_on_q <= 1'b1;
          state_q <= ST_RUN;
        end else begin
          timer_q <= timer_q + 32'h1;
        end
      end
      ST_RUN: begin
        if (cyc_edge) begin
          // RL24 a cycle without peak breaks the run
          peak_cnt_q <= pk_s_q ? peak_cnt_q + 5'h1 : 5'h0;
        end
        // RL7 thermal protection only while on
        if (tsd_hit) begin
          thermal_shutdown_flag <= 1'b1;
          converter_on_q <= 1'b0;
          latch_off_q <= ~auto_restart_enable;
          state_q <= ST_IDLE;
        // RL1 sixteen consecutive peaks
        end else if (peak_cnt_q >= `SHORT_COUNT_LIMIT) begin
          short_circuit_flag <= 1'b1;
          converter_on_q <= 1'b0;
          timer_q <= 32'h0;
          state_q <= ST_FAULT;
        // RL18 hardware or software shutdown
        end else if (!(en_s_q & sel_enable)) begin
          converter_on_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      end
      ST_FAULT: begin
        // RL2 off for 2 ms, then restart or latch
        if (timer_q >= FAULT_OFF_CYCLES - 1) begin
          timer_q <= 32'h0;
          latch_off_q <= ~auto_restart_enable;
          seq_kind_q <= SEQ_FAST;
          state_q <= auto_restart_enable ? ST_INIT : ST_IDLE;
        end else begin
          timer_q <= timer_q + 32'h1;
        end
      end
      default: state_q <= ST_IDLE;
    endcase
  end
end

// ----------------------------------------------------------------
// Thermal warnings, discharge, mode
// ----------------------------------------------------------------
always @(posedge clock or negedge nrst) begin
  if (!nrst) begin
    thermal_warn_flag <= 1'b0;
    prewarn_flag <= 1'b0;
    prewarn_level_q <= `PREWARN_DEFAULT;
    boot_cnt_q <= 32'h0;
    discharge_on_q <= 1'b1;
    pfm_allowed_q <= 1'b0;
  end else if (clk_en) begin
    // RL9 warning sources and threshold select
    thermal_warn_flag <= tw_s_q;
    prewarn_flag <= pw_s_q;
    prewarn_level_q <= prewarn_threshold_sel;
    // RL23 forced mode blocks pulse-frequency transition
    pfm_allowed_q <= ~sel_forced;
    // RL10 boot window, then only on shutdown when enabled
    if (boot_cnt_q < BOOT_DISCHARGE_CYCLES) begin
      boot_cnt_q <= boot_cnt_q + 32'h1;
      discharge_on_q <= 1'b1;
    end else begin
      discharge_on_q <= discharge_enable & ~converter_on_q & (state_q != ST_INIT);
    end
  end
end

// ----------------------------------------------------------------
// Voltage ramp
// ----------------------------------------------------------------
wire ramp_start = active_write | (use_low != use_low_q) | (state_q == ST_INIT);
always @(posedge clock or negedge nrst) begin
  if (!nrst) begin
    vout_target_q <= 7'h0;
    ramp_goal_q <= 7'h0;
    ramp_cnt_q <= 16'h0;
    ramp_down_active_q <= 1'b0;
  end else if (clk_en) begin
    // RL19 rewrite or select change restarts the ramp
    if (ramp_start) begin
      ramp_goal_q <= sel_code;
    end
    if (state_q == ST_INIT) begin
      // RL5 power-up starts from the selected code
      vout_target_q <= sel_code;
      ramp_cnt_q <= 16'h0;
    end else if (vout_target_q != ramp_goal_q) begin
      // RL20 one fixed step per programmed period
      if (ramp_cnt_q >= ramp_period(voltage_ramp_rate) - 16'h1) begin
        ramp_cnt_q <= 16'h0;
        vout_target_q <= (ramp_goal_q > vout_target_q) ? vout_target_q + 7'h1 :
                         vout_target_q - 7'h1;
      end else begin
        ramp_cnt_q <= ramp_cnt_q + 16'h1;
      end
    end else begin
      ramp_cnt_q <= 16'h0;
    end
    // RL21 forced mode actively pulls down on a falling ramp
    ramp_down_active_q <= ramp_transition_mode & (ramp_goal_q < vout_target_q);
  end
end

endmodule // buck_control_sequencer

// ===== test/seq_props.sv
/*
 Port checker for the converter sequencer.
 Assumes one clock domain and the asynchronous active-low nrst; bound to the design top.
*/
`timescale 1ns/1ps
module seq_props (
  input wire clock,
  input wire nrst,
  input wire select_pin_gate,
  input wire forced_mode_high,
  input wire peak_comp,
  input wire [1:0] peak_limit_sel,
  input wire [1:0] peak_threshold_code,
  input wire hs_switch_off,
  input wire converter_on_q,
  input wire [6:0] vout_target_q,
  input wire pfm_allowed_q,
  input wire short_circuit_flag,
  input wire thermal_shutdown_flag,
  input wire i2c_ready_q,
  input wire sleep_mode_q,
  input wire off_mode_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Cycles since reset release
  // ----------------------------------------
  reg [9:0] wake_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      wake_q <= 10'h0;
    else if (wake_q != 10'h3ff)
      wake_q <= wake_q + 10'h1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_hs_open; hs_switch_off == peak_comp; endproperty
  a_hs_open: assert property (p_hs_open) else $error("switch not opened");
  property p_peak_code; peak_threshold_code == peak_limit_sel; endproperty
  a_peak_code: assert property (p_peak_code) else $error("peak code wrong");
  property p_pfm;
    !select_pin_gate [*3] ##0 $stable(forced_mode_high) |-> pfm_allowed_q != forced_mode_high;
  endproperty
  a_pfm: assert property (p_pfm) else $error("pfm permission wrong");
  property p_short_off; $rose(short_circuit_flag) |-> !converter_on_q [*8]; endproperty
  a_short_off: assert property (p_short_off) else $error("on during fault");
  property p_short_hold; short_circuit_flag |=> short_circuit_flag; endproperty
  a_short_hold: assert property (p_short_hold) else $error("fault flag lost");
  property p_tsd_off; $rose(thermal_shutdown_flag) |-> !converter_on_q; endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("on in thermal stop");
  property p_wake_nack; wake_q < 10'h1ef |-> !i2c_ready_q; endproperty
  a_wake_nack: assert property (p_wake_nack) else $error("ready in wake-up");
  property p_wake_ready; wake_q == 10'h1fe |-> i2c_ready_q; endproperty
  a_wake_ready: assert property (p_wake_ready) else $error("not ready");
  property p_ready_hold; i2c_ready_q |=> i2c_ready_q; endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("core dropped");
  property p_ramp_step;
    converter_on_q && $past(converter_on_q) && $changed(vout_target_q) |->
      vout_target_q == $past(vout_target_q) + 7'h1 || vout_target_q == $past(vout_target_q) - 7'h1;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step size");
  property p_ramp_gap;
    converter_on_q && $changed(vout_target_q) |=> ($stable(vout_target_q) || !converter_on_q) [*8];
  endproperty
  a_ramp_gap: assert property (p_ramp_gap) else $error("ramp too fast");
  property p_mode_excl; !(sleep_mode_q && off_mode_q); endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("sleep and off");
endmodule // seq_props

bind buck_control_sequencer seq_props i_seq_props (.clock, .nrst, .select_pin_gate,
  .forced_mode_high, .peak_comp, .peak_limit_sel, .peak_threshold_code, .hs_switch_off,
  .converter_on_q, .vout_target_q, .pfm_allowed_q, .short_circuit_flag, .thermal_shutdown_flag,
  .i2c_ready_q, .sleep_mode_q, .off_mode_q);

// ===== test/power_stage_model.sv
/*
 Power stage model: switching cycle starts every 8 clocks and peak hits on command.
 Assumes load is a one-cycle pulse; hits counts consecutive cycles with a peak.
*/
`timescale 1ns/1ps
module power_stage_model (
  input wire clock,
  input wire nrst,
  input wire load,
  input wire [7:0] hits,
  output wire cycle_start,
  output wire peak_comp
);
  reg [2:0] phase_q;
  reg [7:0] left_q;
  reg peak_q;
  assign cycle_start = ~phase_q[2];
  assign peak_comp = peak_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_q <= 3'h0;
      left_q <= 8'h0;
      peak_q <= 1'b0;
    end else begin
      phase_q <= phase_q + 3'h1;
      if (phase_q == 3'h7) begin
        peak_q <= left_q != 8'h0;
        if (left_q != 8'h0)
          left_q <= left_q - 8'h1;
      end
      if (load)
        left_q <= hits;
    end
  end
endmodule // power_stage_model

// ===== test/test_buck_control_sequencer.sv
/*
 Testbench of the converter sequencer: pins and bits driven as plain levels.
 Assumes the checker is bound to the design and the power stage model feeds it.
*/
`timescale 1ns/1ps
module test_buck_control_sequencer;
  logic clock = 1'b0, nrst = 1'b0, clk_en = 1'b1, enable_pin = 1'b0;
  logic config_select_pin = 1'b0, select_pin_gate = 1'b0, sleep_on_disable = 1'b0;
  logic conv_enable_low = 1'b1, conv_enable_high = 1'b1, vout_low_write = 1'b0;
  logic vout_high_write = 1'b0, forced_mode_low = 1'b0, forced_mode_high = 1'b0;
  logic [6:0] vout_code_low = 7'h3c, vout_code_high = 7'h40;
  logic ramp_transition_mode = 1'b0, auto_restart_enable = 1'b1, discharge_enable = 1'b0;
  logic [1:0] voltage_ramp_rate = 2'h0, peak_limit_sel = 2'h3, prewarn_threshold_sel = 2'h0;
  logic [2:0] powerup_delay = 3'h3;
  logic thermal_shutdown = 1'b0, thermal_warn_comp = 1'b0, prewarn_comp = 1'b0;
  logic burst_load = 1'b0;
  logic [7:0] burst_hits = 8'h0;
  wire cycle_start, peak_comp, hs_switch_off, converter_on_q, pfm_allowed_q;
  wire ramp_down_active_q, discharge_on_q, short_circuit_flag, thermal_shutdown_flag;
  wire thermal_warn_flag, prewarn_flag, i2c_ready_q, sleep_mode_q, off_mode_q;
  wire [1:0] peak_threshold_code, prewarn_level_q;
  wire [6:0] vout_target_q;
  wire [2:0] seq_kind_q;
  int num_errors = 0;
  int check_count = 0;
  int n;
  buck_control_sequencer #(.FAULT_OFF_CYCLES(50), .DELAY_UNIT_CYCLES(20),
    .BOOT_DISCHARGE_CYCLES(10)) i_buck_control_sequencer (.*);
  power_stage_model i_power_stage_model (.clock(clock), .nrst(nrst), .load(burst_load),
    .hits(burst_hits), .cycle_start(cycle_start), .peak_comp(peak_comp));
  always #50 clock = ~clock;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #10;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_on(input logic want, input int lim);
    n = 0;
    while (converter_on_q !== want && n < lim) begin
      cyc(1);
      n++;
    end
    if (converter_on_q !== want) begin
      num_errors++;
      end_sim;
    end
  endtask
  task automatic burst(input logic [7:0] h);
    burst_hits = h;
    burst_load = 1'b1;
    cyc(1);
    burst_load = 1'b0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(10);
    chk(8'(converter_on_q), 8'h0);
    chk(8'({off_mode_q, discharge_on_q, i2c_ready_q}), 8'h6);
    cyc(10);
    nrst = 1'b1;
    cyc(3);
    chk(8'(discharge_on_q), 8'h1);
    cyc(520);
    chk(8'({i2c_ready_q, off_mode_q, discharge_on_q}), 8'h6);
    enable_pin = 1'b1;
    wait_on(1'b1, 700);
    chk(8'(n >= 560 && n <= 575), 8'h1);
    chk(8'(seq_kind_q), 8'h1);
    chk(8'(vout_target_q), 8'h40);
    forced_mode_high = 1'b1;
    cyc(10);
    chk(8'(pfm_allowed_q), 8'h0);
    forced_mode_high = 1'b0;
    for (int i = 0; i < 4; i++) begin
      peak_limit_sel = 2'(i);
      cyc(1);
      chk(8'(peak_threshold_code), 8'(i));
    end
    voltage_ramp_rate = 2'h1;
    vout_code_high = 7'h43;
    vout_high_write = 1'b1;
    cyc(1);
    vout_high_write = 1'b0;
    cyc(15);
    chk(8'(vout_target_q), 8'h40);
    cyc(50);
    chk(8'(vout_target_q), 8'h43);
    voltage_ramp_rate = 2'h0;
    ramp_transition_mode = 1'b1;
    vout_code_high = 7'h40;
    vout_high_write = 1'b1;
    cyc(1);
    vout_high_write = 1'b0;
    cyc(5);
    chk(8'(ramp_down_active_q), 8'h1);
    cyc(40);
    chk(8'(vout_target_q), 8'h40);
    ramp_transition_mode = 1'b0;
    select_pin_gate = 1'b1;
    forced_mode_low = 1'b1;
    cyc(5);
    chk(8'({ramp_down_active_q, pfm_allowed_q}), 8'h0);
    cyc(60);
    chk(8'(vout_target_q), 8'h3c);
    config_select_pin = 1'b1;
    cyc(60);
    chk(8'(vout_target_q), 8'h40);
    config_select_pin = 1'b0;
    select_pin_gate = 1'b0;
    discharge_enable = 1'b1;
    conv_enable_high = 1'b0;
    wait_on(1'b0, 20);
    cyc(1);
    chk(8'({sleep_mode_q, discharge_on_q, i2c_ready_q}), 8'h7);
    conv_enable_high = 1'b1;
    wait_on(1'b1, 700);
    chk(8'(n >= 500 && n <= 510), 8'h1);
    chk(8'(seq_kind_q), 8'h4);
    burst(8'h0f);
    cyc(12);
    chk(8'(hs_switch_off), 8'h1);
    cyc(130);
    burst(8'h0f);
    cyc(160);
    chk(8'({converter_on_q, short_circuit_flag}), 8'h2);
    burst(8'h10);
    wait_on(1'b0, 300);
    chk(8'(short_circuit_flag), 8'h1);
    wait_on(1'b1, 700);
    chk(8'(n >= 545 && n <= 565), 8'h1);
    auto_restart_enable = 1'b0;
    burst(8'h10);
    wait_on(1'b0, 300);
    cyc(700);
    chk(8'(converter_on_q), 8'h0);
    enable_pin = 1'b0;
    cyc(10);
    chk(8'({short_circuit_flag, i2c_ready_q, off_mode_q}), 8'h7);
    enable_pin = 1'b1;
    wait_on(1'b1, 700);
    auto_restart_enable = 1'b1;
    thermal_shutdown = 1'b1;
    wait_on(1'b0, 20);
    chk(8'(thermal_shutdown_flag), 8'h1);
    thermal_shutdown = 1'b0;
    wait_on(1'b1, 700);
    sleep_on_disable = 1'b1;
    enable_pin = 1'b0;
    wait_on(1'b0, 20);
    chk(8'({sleep_mode_q, off_mode_q}), 8'h2);
    powerup_delay = 3'h0;
    enable_pin = 1'b1;
    wait_on(1'b1, 700);
    chk(8'(n >= 500 && n <= 512), 8'h1);
    chk(8'(seq_kind_q), 8'h2);
    thermal_warn_comp = 1'b1;
    prewarn_comp = 1'b1;
    prewarn_threshold_sel = 2'h2;
    cyc(8);
    chk(8'({thermal_warn_flag, prewarn_flag, prewarn_level_q}), 8'he);
    end_sim;
  end
endmodule // test_buck_control_sequencer
